// ==== logic/pps_pkg.sv ====
// pps_pkg: constants and carrier types for the per-port phy control/status bank
// assumes a single switch system clock; all users import pps_pkg::*
package pps_pkg;

  // ==========================================================
  // register offsets (byte addresses in the switch register space)
  localparam logic [7:0] PPS_P1_CTL_OFS = 8'h2d;
  localparam logic [7:0] PPS_P1_STS_OFS = 8'h2e;
  localparam logic [7:0] PPS_P2_CTL_OFS = 8'h3d;
  localparam logic [7:0] PPS_P2_STS_OFS = 8'h3e;
  localparam logic [7:0] PPS_P3_CTL_OFS = 8'h4d;
  localparam logic [7:0] PPS_P4_CTL_OFS = 8'h5d;

  // ==========================================================
  // control register fields
  localparam int PPS_CTL_LED_OFF   = 7;
  localparam int PPS_CTL_TX_DIS    = 6;
  localparam int PPS_CTL_AN_RESTRT = 5;
  localparam int PPS_CTL_PWR_DOWN  = 3;
  localparam int PPS_CTL_XO_DIS    = 2;
  localparam int PPS_CTL_XO_FORCE  = 1;
  localparam int PPS_CTL_MAC_LOOP  = 0;

  localparam logic [7:0] PPS_CTL_PHY_MASK = 8'hef;
  localparam logic [7:0] PPS_CTL_MAC_MASK = 8'h01;
  localparam logic [7:0] PPS_CTL_RST      = 8'h00;
  localparam logic [7:0] PPS_STS_RST      = 8'h00;
  localparam logic [7:0] PPS_RDATA_NONE   = 8'h00;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       mdix;
    logic       an_done;
    logic       link_good;
    logic       lp_flow_ctl;
    logic       lp_100_full;
    logic       lp_100_half;
    logic       lp_10_full;
    logic       lp_10_half;
  } pps_phy_sts_t;

  typedef struct packed {
    logic       tx_disable;
    logic       an_restart;
    logic       power_down;
    logic       auto_mdix_disable;
    logic       crossover_force_select;
  } pps_phy_ctl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } pps_reg_req_t;

endpackage : pps_pkg

// ==== logic/pps_port_regs.sv ====
// pps_port_regs: control 6 register bank for ports 1..4, status 1 for ports 1..2
// assumes the serial management front end presents one-cycle read and
// write strobes on the internal register port, synchronous to clk_sys_i
//
// Operation
// R01: led-blank bit 7 drives both port leds high, else leds follow port logic
// R02: bit 6 disables the port transmitter while set
// R03: writing one to restart bit starts negotiation, then the bit self-clears
// R04: bit 3 holds the port in power-down while set
// R05: bit 2 set disables automatic crossover; reset value zero keeps it on
// R06: with crossover disabled, bit 1 selects mdi-x when one, mdi when zero
// R07: port 1 bit 0 enables mac loopback with port 2 as monitor
// R08: port 1 loopback turns frames at port 1 mac, out via port 2 or 1
// R09: port 3/4 bit 0 enables mac loopback on that port, monitor port 2
// R10: ports 3 and 4 control bits 7..1 are reserved
// R11: status bit 6 reports auto-negotiation done
// R12: status bit 5 reports link good
// R13: status bit 4 reports partner flow-control capability
// R14: status bit 3 reports partner 100bt full-duplex ability
// R15: status bit 2 reports partner 100bt half-duplex ability
// R16: status bit 1 reports partner 10bt full-duplex ability
// R17: status bit 0 reports partner 10bt half-duplex ability
// R18: reserved bits read zero, ignore writes; status reads zero after reset
`timescale 1ns/100ps

module pps_port_regs
  import pps_pkg::*;
#(
  parameter int NUM_PHY = 2
)(
  input  wire logic                       clk_sys_i,
  input  wire logic                       nrst_i,
  input  wire pps_reg_req_t               reg_req_i,
  output logic [7:0]                      reg_rdata_o,
  output logic                            reg_rvalid_o,
  input  wire pps_phy_sts_t [NUM_PHY-1:0] phy_sts_i,
  input  wire logic [NUM_PHY-1:0]         port_led_first_i,
  input  wire logic [NUM_PHY-1:0]         port_led_second_i,
  output logic [NUM_PHY-1:0]              port_led_first_o,
  output logic [NUM_PHY-1:0]              port_led_second_o,
  output pps_phy_ctl_t [NUM_PHY-1:0]      phy_ctl_o,
  output logic [3:0]                      mac_loop_en_o,
  output logic [3:0]                      mac_loop_monitor_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [NUM_PHY-1:0][7:0] ctl;
    logic [1:0]              mac_ctl;
    logic [NUM_PHY-1:0][7:0] sts;
    logic [7:0]              rdata;
    logic                    rvalid;
    logic [NUM_PHY-1:0]      an_pulse;
    logic [NUM_PHY-1:0]      led_first;
    logic [NUM_PHY-1:0]      led_second;
  } pps_state_t;

  pps_state_t state_r;
  pps_state_t state_nxt;

  // ==========================================================
  // helpers
  function automatic logic [7:0] pps_ctl_ofs(input int port);
    return (port == 0) ? PPS_P1_CTL_OFS : PPS_P2_CTL_OFS;
  endfunction : pps_ctl_ofs

  function automatic logic [7:0] pps_sts_ofs(input int port);
    return (port == 0) ? PPS_P1_STS_OFS : PPS_P2_STS_OFS;
  endfunction : pps_sts_ofs

  // ==========================================================
  // next state
  always_comb
  begin
    state_nxt        = state_r;
    state_nxt.rvalid = reg_req_i.rd;
    state_nxt.rdata  = PPS_RDATA_NONE;                              // [R18]

    for (int p = 0; p < NUM_PHY; p++)
    begin
      // status is resampled every cycle so software sees live port state
      state_nxt.sts[p] = phy_sts_i[p];                              // [R11] [R12] [R13]
      // one cycle of restart bit launches negotiation and clears the bit
      state_nxt.an_pulse[p] = state_r.ctl[p][PPS_CTL_AN_RESTRT];    // [R03]
      state_nxt.ctl[p][PPS_CTL_AN_RESTRT] = 1'b0;                   // [R03]
      if (reg_req_i.wr && reg_req_i.addr == pps_ctl_ofs(p))
      begin
        // reserved bit 4 is masked off
        state_nxt.ctl[p] = reg_req_i.wdata & PPS_CTL_PHY_MASK;      // [R18]
      end
      if (reg_req_i.rd && reg_req_i.addr == pps_ctl_ofs(p))
      begin
        state_nxt.rdata = state_r.ctl[p];
      end
      if (reg_req_i.rd && reg_req_i.addr == pps_sts_ofs(p))
      begin
        state_nxt.rdata = state_r.sts[p];                           // [R14] [R15] [R16] [R17]
      end
      // blanking forces both pins high, the off level of the leds
      state_nxt.led_first[p]  = port_led_first_i[p]
                                | state_r.ctl[p][PPS_CTL_LED_OFF];  // [R01]
      state_nxt.led_second[p] = port_led_second_i[p]
                                | state_r.ctl[p][PPS_CTL_LED_OFF];  // [R01]
    end

    if (reg_req_i.wr && reg_req_i.addr == PPS_P3_CTL_OFS)
    begin
      state_nxt.mac_ctl[0] = reg_req_i.wdata[PPS_CTL_MAC_LOOP];     // [R10]
    end
    if (reg_req_i.wr && reg_req_i.addr == PPS_P4_CTL_OFS)
    begin
      state_nxt.mac_ctl[1] = reg_req_i.wdata[PPS_CTL_MAC_LOOP];     // [R10]
    end
    if (reg_req_i.rd && reg_req_i.addr == PPS_P3_CTL_OFS)
    begin
      state_nxt.rdata = {7'b000_0000, state_r.mac_ctl[0]} & PPS_CTL_MAC_MASK; // [R10]
    end
    if (reg_req_i.rd && reg_req_i.addr == PPS_P4_CTL_OFS)
    begin
      state_nxt.rdata = {7'b000_0000, state_r.mac_ctl[1]} & PPS_CTL_MAC_MASK; // [R10]
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int p = 0; p < NUM_PHY; p++)
      begin
        state_r.ctl[p] <= PPS_CTL_RST;
        state_r.sts[p] <= PPS_STS_RST;                              // [R18]
      end
      state_r.mac_ctl    <= '0;
      state_r.rdata      <= PPS_RDATA_NONE;
      state_r.rvalid     <= 1'b0;
      state_r.an_pulse   <= '0;
      state_r.led_first  <= '1;
      state_r.led_second <= '1;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // outputs, all taken from state flops
  always_comb
  begin
    for (int p = 0; p < NUM_PHY; p++)
    begin
      phy_ctl_o[p].tx_disable        = state_r.ctl[p][PPS_CTL_TX_DIS];   // [R02]
      phy_ctl_o[p].an_restart        = state_r.an_pulse[p];              // [R03]
      phy_ctl_o[p].power_down        = state_r.ctl[p][PPS_CTL_PWR_DOWN]; // [R04]
      phy_ctl_o[p].auto_mdix_disable = state_r.ctl[p][PPS_CTL_XO_DIS];   // [R05]
      // force select only matters while auto crossover is off
      phy_ctl_o[p].crossover_force_select = state_r.ctl[p][PPS_CTL_XO_FORCE]; // [R06]
    end
  end

  assign port_led_first_o  = state_r.led_first;
  assign port_led_second_o = state_r.led_second;
  assign reg_rdata_o       = state_r.rdata;
  assign reg_rvalid_o      = state_r.rvalid;

  // port 1 loop returns via port 2; port 2 loop has no documented monitor
  assign mac_loop_en_o = {state_r.mac_ctl[1], state_r.mac_ctl[0],
                          state_r.ctl[1][PPS_CTL_MAC_LOOP],
                          state_r.ctl[0][PPS_CTL_MAC_LOOP]};        // [R07] [R08] [R09]
  // port 2 becomes monitor whenever port 1, 3 or 4 loops
  assign mac_loop_monitor_o = {2'b00,
                               state_r.ctl[0][PPS_CTL_MAC_LOOP]
                               | state_r.mac_ctl[0] | state_r.mac_ctl[1],
                               1'b0};                               // [R07] [R09]

endmodule : pps_port_regs

// ==== sim/pps_chk.sv ====
// pps_chk: pin-level assertions on the port control/status bank
// assumes one clock domain; bound to every pps_port_regs instance
`timescale 1ns/100ps
module pps_chk
  import pps_pkg::*;
#(
  parameter int NUM_PHY = 2
)(
  input  wire logic                       clk_sys_i,
  input  wire logic                       nrst_i,
  input  wire pps_reg_req_t               reg_req_i,
  input  wire logic [7:0]                 reg_rdata_o,
  input  wire logic                       reg_rvalid_o,
  input  wire pps_phy_sts_t [NUM_PHY-1:0] phy_sts_i,
  input  wire logic [NUM_PHY-1:0]         port_led_first_i,
  input  wire logic [NUM_PHY-1:0]         port_led_second_i,
  input  wire logic [NUM_PHY-1:0]         port_led_first_o,
  input  wire logic [NUM_PHY-1:0]         port_led_second_o,
  input  wire pps_phy_ctl_t [NUM_PHY-1:0] phy_ctl_o,
  input  wire logic [3:0]                 mac_loop_en_o,
  input  wire logic [3:0]                 mac_loop_monitor_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  logic w1;
  logic w2;
  logic w3;
  logic [7:0] wd;
  assign w1 = reg_req_i.wr && reg_req_i.addr == 8'h2d;
  assign w2 = reg_req_i.wr && reg_req_i.addr == 8'h3d;
  assign w3 = reg_req_i.wr && reg_req_i.addr == 8'h4d;
  assign wd = reg_req_i.wdata;
  // ==========================================================
  // control side
  property p_led; w1 && wd[7] |-> ##2 port_led_first_o[0] && port_led_second_o[0]; endproperty
  a_led: assert property (p_led) else $error("led blank not seen");
  property p_txd; w1 |=> phy_ctl_o[0].tx_disable == $past(wd[6]); endproperty
  a_txd: assert property (p_txd) else $error("tx disable wrong");
  property p_an; w1 && wd[5] |-> ##2 phy_ctl_o[0].an_restart ##1 !phy_ctl_o[0].an_restart; endproperty
  a_an: assert property (p_an) else $error("restart pulse wrong");
  property p_pd; w2 |=> phy_ctl_o[1].power_down == $past(wd[3]); endproperty
  a_pd: assert property (p_pd) else $error("power down wrong");
  property p_xo; w2 |=> {phy_ctl_o[1].auto_mdix_disable, phy_ctl_o[1].crossover_force_select}
    == $past(wd[2:1]); endproperty
  a_xo: assert property (p_xo) else $error("crossover wrong");
  property p_ml; w3 |=> mac_loop_en_o[2] == $past(wd[0]); endproperty
  a_ml: assert property (p_ml) else $error("port 3 loop wrong");
  property p_mon; mac_loop_en_o[0] && $past(mac_loop_en_o[0]) |-> mac_loop_monitor_o[1]; endproperty
  a_mon: assert property (p_mon) else $error("monitor not flagged");
  // ==========================================================
  // read side
  property p_sts; reg_req_i.rd && reg_req_i.addr == 8'h2e && $stable(phy_sts_i[0])
    |=> reg_rvalid_o && reg_rdata_o == $past(phy_sts_i[0]); endproperty
  a_sts: assert property (p_sts) else $error("status read wrong");
  property p_rsv; reg_req_i.rd && reg_req_i.addr == 8'h4d |=> reg_rdata_o[7:1] == 7'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_b4; reg_req_i.rd && reg_req_i.addr == 8'h2d |=> reg_rvalid_o && !reg_rdata_o[4]; endproperty
  a_b4: assert property (p_b4) else $error("bit 4 set");
  c_an: cover property (w1 && wd[5]);
  c_mon: cover property (mac_loop_monitor_o[1]);
  c_rd: cover property (reg_rvalid_o && reg_rdata_o != 8'h00);
endmodule : pps_chk

bind pps_port_regs pps_chk #(.NUM_PHY(NUM_PHY)) u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .phy_sts_i(phy_sts_i), .port_led_first_i(port_led_first_i),
  .port_led_second_i(port_led_second_i), .port_led_first_o(port_led_first_o),
  .port_led_second_o(port_led_second_o), .phy_ctl_o(phy_ctl_o),
  .mac_loop_en_o(mac_loop_en_o), .mac_loop_monitor_o(mac_loop_monitor_o));

// ==== sim/pps_port_regs_tb.sv ====
// pps_port_regs_tb: random register traffic against the port bank
// assumes default NUM_PHY and the checker bound from pps_chk.sv
`timescale 1ns/100ps
module pps_port_regs_tb
  import pps_pkg::*;
;
  logic               clk_sys_i = 1'b0;
  logic               nrst_i = 1'b0;
  pps_reg_req_t       req = '0;
  logic [7:0]         rdata;
  logic               rvalid;
  pps_phy_sts_t [1:0] sts = '0;
  logic [1:0]         li1 = '0, li2 = '0, lo1, lo2;
  pps_phy_ctl_t [1:0] ctl;
  logic [3:0]         lp, mon;
  logic [7:0]         mdl [4] = '{default: 8'h00};
  logic [7:0]         d;
  logic [3:0]         ml;
  int                 mismatches = 0, tests_run = 0, seed = 32'hbc34, p;
  pps_port_regs dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .phy_sts_i(sts), .port_led_first_i(li1), .port_led_second_i(li2),
    .port_led_first_o(lo1), .port_led_second_o(lo2), .phy_ctl_o(ctl), .mac_loop_en_o(lp),
    .mac_loop_monitor_o(mon));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  // ==========================================================
  // tasks
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one strobe; returns in the cycle where the read answer stands, since rvalid lasts one cycle
  task automatic acc(logic [7:0] a, logic w, logic r, logic [7:0] wd);
    @(negedge clk_sys_i);
    req = '{a, w, r, wd};
    @(negedge clk_sys_i);
    req = '0;
  endtask : acc
  task automatic rd(logic [7:0] a, logic [7:0] e);
    acc(a, 1'b0, 1'b1, 8'h00);
    chk("rvalid", 8'h01, {7'h0, rvalid});
    chk("rdata", e, rdata);
  endtask : rd
  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (16) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    foreach (mdl[i]) rd(8'h2d + 8'(i) * 8'h10, 8'h00);
    rd(8'h2e, 8'h00);
    rd(8'h3e, 8'h00);
    acc(8'h5f, 1'b1, 1'b0, 8'hff);
    rd(8'h5f, 8'h00);
    for (int i = 0; i < 40; i++)
    begin
      p = (i < 4) ? i : $random(seed) & 3;
      d = (i < 4) ? 8'hff : 8'($random(seed));
      {li1, li2} = 4'($random(seed));
      sts = 16'($random(seed));
      if (i == 20)
      begin
        nrst_i = 1'b0;
        mdl = '{default: 8'h00};
        @(negedge clk_sys_i);
        nrst_i = 1'b1;
        rd(8'h2d, 8'h00);
      end
      acc(8'h2d + 8'(p) * 8'h10, 1'b1, 1'b0, d);
      mdl[p] = (p < 2) ? d & 8'hcf : d & 8'h01;
      rd(8'h2d + 8'(p) * 8'h10, mdl[p]);
      ml = {mdl[3][0], mdl[2][0], mdl[1][0], mdl[0][0]};
      chk("loop", {4'h0, ml}, {4'h0, lp});
      chk("mon", {6'h0, ml[0] | ml[2] | ml[3], 1'b0}, {4'h0, mon});
      if (p < 2)
      begin
        chk("led", {6'h0, li1[p] | d[7], li2[p] | d[7]}, {6'h0, lo1[p], lo2[p]});
        chk("phy", {3'h0, d[6], 1'b0, d[3:1]}, {3'h0, ctl[p]});
      end
      rd(8'h2e + 8'(p & 1) * 8'h10, sts[p & 1]);
    end
    wrap_up();
  end
endmodule : pps_port_regs_tb
